// *** rtl/kisc_evt_if.sv ***
// Event status and mask signals between the top and its event register
`timescale 1ns/10ps
interface kisc_evt_if;
    import kisc_pkg::*;
    kisc_evt_t set;
    kisc_evt_t clr;
    kisc_evt_t mask_wdata;
    logic mask_we;
    kisc_evt_t status;
    kisc_evt_t mask;
    modport owner (
        input set, clr, mask_wdata, mask_we,
        output status, mask
    );
    modport user (
        output set, clr, mask_wdata, mask_we,
        input status, mask
    );
endinterface

// *** rtl/kisc_evt_regs.sv ***
// Sticky event status with write-one-to-clear and mask
`timescale 1ns/10ps
module kisc_evt_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Event carrier
    kisc_evt_if.owner ev
);
    import kisc_pkg::*;
    kisc_evt_t status_reg;
    kisc_evt_t mask_reg;

    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= KISC_EVT_RESET;
        end else begin
            status_reg <= (status_reg & ~ev.clr) | ev.set;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= KISC_EVT_RESET;
        end else if (ev.mask_we) begin
            mask_reg <= ev.mask_wdata;
        end
    end

    assign ev.status = status_reg;
    assign ev.mask = mask_reg;
endmodule

// *** rtl/kisc_pin_detect.sv ***
// Input synchroniser with falling edge and low level detection
`timescale 1ns/10ps
module kisc_pin_detect (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Asynchronous active-low input
    input wire logic pin_n,
    // Detection results
    output logic fall,
    output logic low
);
    import kisc_pkg::*;
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;

    // RULE10: two-flop input sync
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= KISC_PIN_IDLE;
            sync2_reg <= KISC_PIN_IDLE;
            prev_reg <= KISC_PIN_IDLE;
        end else begin
            sync1_reg <= pin_n;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign fall = prev_reg & ~sync2_reg;
    assign low = ~sync2_reg;
endmodule

// *** rtl/kisc_pkg.sv ***
// Constants and types shared by the keyboard interrupt status/control block
package kisc_pkg;
    // Sources: port A pins, then auto wakeup at the top index
    localparam int KISC_PINS = 6;
    localparam int KISC_SRC = KISC_PINS + 1;
    localparam int KISC_AWU_IDX = KISC_PINS;
    typedef logic [7:0] kisc_byte_t;
    typedef logic [15:0] kisc_addr_t;
    typedef logic [KISC_SRC-1:0] kisc_src_t;
    ////////////////////////////////////////////////////////////////////////
    // Register addresses
    localparam kisc_addr_t KISC_STATUS_ADDR = 16'h001A;
    localparam kisc_addr_t KISC_ENABLE_ADDR = 16'h001B;
    localparam kisc_addr_t KISC_BREAK_ADDR = 16'h001C;
    localparam kisc_addr_t KISC_EVT_ADDR = 16'h001D;
    localparam kisc_addr_t KISC_EVMASK_ADDR = 16'h001E;
    ////////////////////////////////////////////////////////////////////////
    // Status/control field positions
    localparam int KISC_MODE_BIT = 0;
    localparam int KISC_IMASK_BIT = 1;
    localparam int KISC_ACK_BIT = 2;
    localparam int KISC_FLAG_BIT = 3;
    localparam int KISC_UPPER_LSB = 4;
    localparam int KISC_UPPER_MSB = 7;
    localparam int KISC_BREAK_FLAG_CLEAR_ENABLE_BIT = 0;
    ////////////////////////////////////////////////////////////////////////
    // Event status: new latch, refused acknowledge
    localparam int KISC_EVT_W = 2;
    localparam int KISC_EVT_LATCH = 0;
    localparam int KISC_EVT_REFUSED = 1;
    typedef logic [KISC_EVT_W-1:0] kisc_evt_t;
    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam kisc_byte_t KISC_RESET_BYTE = 8'h00;
    localparam kisc_src_t KISC_ENABLE_RESET = 7'h00;
    localparam kisc_evt_t KISC_EVT_RESET = 2'h0;
    localparam logic KISC_BIT_RESET = 1'b0;
    localparam logic KISC_PIN_IDLE = 1'b1;
endpackage

// *** rtl/kisc_top.sv ***
// Keyboard interrupt status and control block with register port
// Operation
// RULE1: Upper four status bits read zero
// RULE2: Pending flag shows latched keyboard request
// RULE3: Reset clears the pending flag
// RULE4: Writing acknowledge one clears latch; zero nothing
// RULE5: Acknowledge bit stores nothing, reads zero
// RULE6: Mask bit blocks the CPU request
// RULE7: Sensitivity bit adds low levels to edges
// RULE8: Reset clears mask and sensitivity bits
// RULE9: Acknowledge ignored in break unless enabled
// RULE10: Inputs synchronised; new request beats acknowledge
`timescale 1ns/10ps
module kisc_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire kisc_pkg::kisc_addr_t reg_addr,
    input wire kisc_pkg::kisc_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output kisc_pkg::kisc_byte_t reg_rdata,
    // Keyboard pins and auto wakeup, active low
    input wire logic [kisc_pkg::KISC_PINS-1:0] kbd_pin_n,
    input wire logic awu_req_n,
    // Debugger break state
    input wire logic break_state,
    // Interrupt outputs
    output logic kbd_irq,
    output logic evt_irq
);
    import kisc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Control and status state
    logic kbd_request_mask_reg;
    logic kbd_level_sensitive_reg;
    logic kbd_pending_flag_reg;
    logic kbd_pending_flag_next;
    logic break_flag_clear_enable_reg;
    kisc_src_t enable_reg;
    kisc_byte_t rdata_reg;
    kisc_byte_t rdata_next;
    logic kbd_irq_reg;
    logic evt_irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    logic sel_status;
    logic sel_enable;
    logic sel_break;
    logic sel_evt;
    logic sel_evmask;
    logic wr_status;
    logic ack_write;
    logic ack_taken;
    logic ack_refused;

    assign sel_status = (reg_addr == KISC_STATUS_ADDR);
    assign sel_enable = (reg_addr == KISC_ENABLE_ADDR);
    assign sel_break = (reg_addr == KISC_BREAK_ADDR);
    assign sel_evt = (reg_addr == KISC_EVT_ADDR);
    assign sel_evmask = (reg_addr == KISC_EVMASK_ADDR);
    assign wr_status = reg_wr & sel_status;
    assign ack_write = wr_status & reg_wdata[KISC_ACK_BIT];

    // RULE9: break state gates acknowledge
    assign ack_taken = ack_write & (~break_state | break_flag_clear_enable_reg);
    assign ack_refused = ack_write & ~ack_taken;

    ////////////////////////////////////////////////////////////////////////
    // Input detection
    kisc_src_t src_n;
    kisc_src_t src_fall;
    kisc_src_t src_low;
    kisc_src_t src_hit;
    logic set_req;

    assign src_n = {awu_req_n, kbd_pin_n};

    // RULE10: every source synchronised first
    genvar gi;
    generate
        for (gi = 0; gi < KISC_SRC; gi++) begin : g_src
            kisc_pin_detect u_det (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .pin_n(src_n[gi]),
                .fall(src_fall[gi]),
                .low(src_low[gi])
            );
        end
    endgenerate

    // RULE7: edges always, low levels in level mode
    assign src_hit = src_fall | ({KISC_SRC{kbd_level_sensitive_reg}} & src_low);
    assign set_req = |(enable_reg & src_hit);

    ////////////////////////////////////////////////////////////////////////
    // Pending latch
    // RULE10: new request wins over acknowledge
    always_comb begin
        kbd_pending_flag_next = kbd_pending_flag_reg;
        if (set_req) begin
            kbd_pending_flag_next = 1'b1;
        end else if (ack_taken) begin
            // RULE4: acknowledge clears latch
            kbd_pending_flag_next = 1'b0;
        end
    end

    // RULE3: reset clears pending
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            kbd_pending_flag_reg <= KISC_BIT_RESET;
        end else begin
            // RULE2: pending follows latched request
            kbd_pending_flag_reg <= kbd_pending_flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mask and sensitivity bits
    // RULE8: both cleared by reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            kbd_request_mask_reg <= KISC_BIT_RESET;
            kbd_level_sensitive_reg <= KISC_BIT_RESET;
        end else if (wr_status) begin
            kbd_request_mask_reg <= reg_wdata[KISC_IMASK_BIT];
            kbd_level_sensitive_reg <= reg_wdata[KISC_MODE_BIT];
        end
    end

    // Source enables
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_reg <= KISC_ENABLE_RESET;
        end else if (reg_wr & sel_enable) begin
            enable_reg <= reg_wdata[KISC_SRC-1:0];
        end
    end

    // Break flag clear enable, default off
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            break_flag_clear_enable_reg <= KISC_BIT_RESET;
        end else if (reg_wr & sel_break) begin
            break_flag_clear_enable_reg <= reg_wdata[KISC_BREAK_FLAG_CLEAR_ENABLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event status and mask
    kisc_evt_if ev ();
    kisc_evt_t evt_set;

    always_comb begin
        evt_set = KISC_EVT_RESET;
        evt_set[KISC_EVT_LATCH] = set_req & ~kbd_pending_flag_reg;
        evt_set[KISC_EVT_REFUSED] = ack_refused;
    end

    assign ev.set = evt_set;
    assign ev.clr = (reg_wr & sel_evt) ? reg_wdata[KISC_EVT_W-1:0] : KISC_EVT_RESET;
    assign ev.mask_we = reg_wr & sel_evmask;
    assign ev.mask_wdata = reg_wdata[KISC_EVT_W-1:0];

    kisc_evt_regs u_evt (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ev(ev)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interrupt outputs
    // RULE6: mask gates the CPU request
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            kbd_irq_reg <= KISC_BIT_RESET;
        end else begin
            kbd_irq_reg <= kbd_pending_flag_reg & ~kbd_request_mask_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            evt_irq_reg <= KISC_BIT_RESET;
        end else begin
            evt_irq_reg <= |(ev.status & ev.mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    always_comb begin
        rdata_next = KISC_RESET_BYTE;
        if (sel_status) begin
            // RULE1: upper bits stay zero
            // RULE5: acknowledge position reads zero
            rdata_next[KISC_FLAG_BIT] = kbd_pending_flag_reg;
            rdata_next[KISC_IMASK_BIT] = kbd_request_mask_reg;
            rdata_next[KISC_MODE_BIT] = kbd_level_sensitive_reg;
        end else if (sel_enable) begin
            rdata_next[KISC_SRC-1:0] = enable_reg;
        end else if (sel_break) begin
            rdata_next[KISC_BREAK_FLAG_CLEAR_ENABLE_BIT] = break_flag_clear_enable_reg;
        end else if (sel_evt) begin
            rdata_next[KISC_EVT_W-1:0] = ev.status;
        end else if (sel_evmask) begin
            rdata_next[KISC_EVT_W-1:0] = ev.mask;
        end
    end

    // Data stand only in the cycle after the read
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= KISC_RESET_BYTE;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= KISC_RESET_BYTE;
        end
    end

    assign reg_rdata = rdata_reg;
    assign kbd_irq = kbd_irq_reg;
    assign evt_irq = evt_irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence status_read_s;
        reg_rd && sel_status;
    endsequence

    sequence ack_in_break_s;
        ack_write && break_state && !break_flag_clear_enable_reg;
    endsequence

    sequence ack_clean_s;
        ack_taken && !set_req;
    endsequence

    upper_bits_a: assert property (status_read_s |=> // RULE1
        reg_rdata[KISC_UPPER_MSB:KISC_UPPER_LSB] == 4'h0)
        else $error("upper status bits not zero");

    pending_read_a: assert property (status_read_s |=> // RULE2
        reg_rdata[KISC_FLAG_BIT] == $past(kbd_pending_flag_reg))
        else $error("pending flag read mismatch");

    pending_set_a: assert property (set_req |=> kbd_pending_flag_reg) // RULE2
        else $error("request did not set pending");

    reset_clear_a: assert property (disable iff (1'b0) // RULE3
        $rose(reset_n) |-> !kbd_pending_flag_reg)
        else $error("pending not cleared by reset");

    ack_clear_a: assert property (ack_clean_s |=> !kbd_pending_flag_reg ##1 // RULE4
        (kbd_pending_flag_reg || !kbd_irq))
        else $error("acknowledge did not clear");

    ack_zero_a: assert property (wr_status && !reg_wdata[KISC_ACK_BIT] && // RULE4
        kbd_pending_flag_reg |=> kbd_pending_flag_reg)
        else $error("zero acknowledge changed latch");

    ack_reads_a: assert property (status_read_s |=> !reg_rdata[KISC_ACK_BIT]) // RULE5
        else $error("acknowledge bit read as one");

    mask_block_a: assert property (kbd_request_mask_reg && // RULE6
        $stable(kbd_request_mask_reg) |=> !kbd_irq)
        else $error("masked request reached cpu");

    mask_pass_a: assert property (kbd_pending_flag_reg && // RULE6
        !kbd_request_mask_reg |=> kbd_irq)
        else $error("unmasked request lost");

    level_mode_a: assert property (kbd_level_sensitive_reg && // RULE7
        |(enable_reg & src_low) |=> kbd_pending_flag_reg)
        else $error("low level ignored in level mode");

    edge_only_a: assert property (!kbd_pending_flag_reg && // RULE7
        !kbd_level_sensitive_reg && !(|(enable_reg & src_fall)) |=> !kbd_pending_flag_reg)
        else $error("set without edge in edge mode");

    reset_mode_a: assert property (disable iff (1'b0) // RULE8
        $rose(reset_n) |-> !kbd_request_mask_reg && !kbd_level_sensitive_reg)
        else $error("mask or mode not cleared by reset");

    break_keep_a: assert property (ack_in_break_s ##0 kbd_pending_flag_reg // RULE9
        |=> kbd_pending_flag_reg ##0 ev.status[KISC_EVT_REFUSED])
        else $error("acknowledge in break disturbed latch");

    set_wins_a: assert property (set_req && ack_taken |=> // RULE10
        kbd_pending_flag_reg)
        else $error("acknowledge beat a new request");

    evt_irq_a: assert property (|(ev.status & ev.mask) |=> evt_irq)
        else $error("event interrupt missing");
endmodule

// *** verif/kisc_kbd_model.sv ***
// Keyboard pin and auto wakeup source model, active low with pull-up idle
`timescale 1ns/10ps
module kisc_kbd_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Press request per source, pins first, auto wakeup on top
    input wire kisc_pkg::kisc_src_t press,
    // Active-low source lines
    output logic [kisc_pkg::KISC_PINS-1:0] kbd_pin_n,
    output logic awu_req_n
);
    import kisc_pkg::*;
    // Released lines float to the pull-up level
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            kbd_pin_n <= '1;
            awu_req_n <= KISC_PIN_IDLE;
        end else begin
            kbd_pin_n <= ~press[KISC_PINS-1:0];
            awu_req_n <= ~press[KISC_AWU_IDX];
        end
    end
endmodule

// *** verif/tb_kisc_top.sv ***
// Self-checking bench for the keyboard interrupt status and control block
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD %0t: got %h expected %h", $time, got, exp); end end
module tb_kisc_top;
    import kisc_pkg::*;
    logic sys_clk;
    logic reset_n;
    kisc_addr_t reg_addr;
    kisc_byte_t reg_wdata;
    logic reg_wr;
    logic reg_rd;
    kisc_byte_t reg_rdata;
    logic [KISC_PINS-1:0] kbd_pin_n;
    logic awu_req_n;
    logic break_state;
    logic kbd_irq;
    logic evt_irq;
    kisc_src_t press;
    int num_errors = 0;
    int tests_run = 0;
    ////////////////////////////////////////////////////////////////////////
    kisc_top uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .kbd_pin_n(kbd_pin_n), .awu_req_n(awu_req_n), .break_state(break_state),
        .kbd_irq(kbd_irq), .evt_irq(evt_irq));
    kisc_kbd_model kbd (.sys_clk(sys_clk), .reset_n(reset_n), .press(press),
        .kbd_pin_n(kbd_pin_n), .awu_req_n(awu_req_n));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input kisc_addr_t a, input kisc_byte_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input kisc_addr_t a, input kisc_byte_t e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
        // Return on an edge so later stimulus lands right after it
        @(posedge sys_clk);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Whole sequence needs well under 1000 cycles
    initial begin
        cyc(5000);
        num_errors++;
        test_done;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        break_state = 1'b0;
        press = 7'h00;
        cyc(4);
        reset_n <= 1'b1;
        // Reset values and an unmapped place
        rd(KISC_STATUS_ADDR, 8'h00);
        rd(KISC_ENABLE_ADDR, 8'h00);
        rd(KISC_BREAK_ADDR, 8'h00);
        rd(KISC_EVT_ADDR, 8'h00);
        rd(KISC_EVMASK_ADDR, 8'h00);
        rd(16'h0020, 8'h00);
        `CHK(kbd_irq, 1'b0)
        // Upper bits and acknowledge never read back
        wr(KISC_STATUS_ADDR, 8'hFF);
        rd(KISC_STATUS_ADDR, 8'h03);
        wr(KISC_STATUS_ADDR, 8'h00);
        // Disabled source is ignored
        press <= 7'h01;
        cyc(6);
        rd(KISC_STATUS_ADDR, 8'h00);
        press <= 7'h00;
        wr(KISC_ENABLE_ADDR, 8'h7F);
        rd(KISC_ENABLE_ADDR, 8'h7F);
        // Pin edge latches, zero write keeps, one write clears
        press <= 7'h01;
        cyc(6);
        rd(KISC_STATUS_ADDR, 8'h08);
        `CHK(kbd_irq, 1'b1)
        press <= 7'h00;
        wr(KISC_STATUS_ADDR, 8'h00);
        rd(KISC_STATUS_ADDR, 8'h08);
        wr(KISC_STATUS_ADDR, 8'h04);
        rd(KISC_STATUS_ADDR, 8'h00);
        `CHK(kbd_irq, 1'b0)
        // Held low auto wakeup: edge only, then level mode
        press <= 7'h40;
        cyc(6);
        rd(KISC_STATUS_ADDR, 8'h08);
        wr(KISC_STATUS_ADDR, 8'h04);
        rd(KISC_STATUS_ADDR, 8'h00);
        wr(KISC_STATUS_ADDR, 8'h01);
        cyc(4);
        rd(KISC_STATUS_ADDR, 8'h09);
        wr(KISC_STATUS_ADDR, 8'h05);
        rd(KISC_STATUS_ADDR, 8'h09);
        press <= 7'h00;
        cyc(4);
        wr(KISC_STATUS_ADDR, 8'h05);
        rd(KISC_STATUS_ADDR, 8'h01);
        // Masked request latches but stays off the CPU line
        wr(KISC_STATUS_ADDR, 8'h02);
        wr(KISC_EVT_ADDR, 8'h03);
        press <= 7'h20;
        cyc(6);
        rd(KISC_STATUS_ADDR, 8'h0A);
        `CHK(kbd_irq, 1'b0)
        press <= 7'h00;
        // Acknowledge in break state is refused by default
        break_state <= 1'b1;
        wr(KISC_STATUS_ADDR, 8'h06);
        rd(KISC_STATUS_ADDR, 8'h0A);
        rd(KISC_EVT_ADDR, 8'h03);
        wr(KISC_EVMASK_ADDR, 8'h02);
        cyc(2);
        `CHK(evt_irq, 1'b1)
        wr(KISC_EVMASK_ADDR, 8'h00);
        cyc(2);
        `CHK(evt_irq, 1'b0)
        wr(KISC_EVMASK_ADDR, 8'h03);
        wr(KISC_EVT_ADDR, 8'h03);
        cyc(2);
        rd(KISC_EVT_ADDR, 8'h00);
        `CHK(evt_irq, 1'b0)
        wr(KISC_BREAK_ADDR, 8'h01);
        wr(KISC_STATUS_ADDR, 8'h06);
        rd(KISC_STATUS_ADDR, 8'h02);
        break_state <= 1'b0;
        // Reset in mid-run with a request latched
        wr(KISC_STATUS_ADDR, 8'h01);
        press <= 7'h01;
        cyc(6);
        reset_n <= 1'b0;
        cyc(2);
        reset_n <= 1'b1;
        press <= 7'h00;
        rd(KISC_STATUS_ADDR, 8'h00);
        rd(KISC_ENABLE_ADDR, 8'h00);
        rd(KISC_BREAK_ADDR, 8'h00);
        `CHK(kbd_irq, 1'b0)
        test_done;
    end
endmodule
